// ===== adsp_regs.svh
// Purpose: constants for the analog and display shared port block
// Assumes: included by its bare name from the port slice and the port block files
// Notes: reset values, field positions, widths, port counts and read fill values only; no logic here
`ifndef ADSP_REGS_SVH
`define ADSP_REGS_SVH

// port geometry
`define ADSP_DATA_W 8
`define ADSP_NARROW_W 5
`define ADSP_WIDE_PORTS 6
`define ADSP_ANALOG_PORTS 2

// reset values
`define ADSP_RST_BIT 1'b0
`define ADSP_RST_ANA_DIS 1'b0
`define ADSP_RST_SEGSEL 6'h00

// field positions
`define ADSP_ANA_DIS_BIT 0
`define ADSP_SEGSEL_MSB 5
`define ADSP_SEGSEL_LSB 0

// read values of unimplemented or write-only locations
`define ADSP_UNDEF_FILL 3'h0
`define ADSP_WO_READ 8'h00
`define ADSP_CTRL_PAD 2'h0

`endif

// ===== adsp_pkg.sv
// Purpose: types shared by the shared port block
// Assumes: nothing imported; users write adsp_pkg::name
// Notes: command and answer travel as packed structs
package adsp_pkg;

  // what a command addresses; first six are the 8-bit ports in array order
  typedef enum logic [3:0] {
    ADSP_T_ANALOG_A,
    ADSP_T_ANALOG_B,
    ADSP_T_DISPLAY_A,
    ADSP_T_DISPLAY_B,
    ADSP_T_DISPLAY_C,
    ADSP_T_DISPLAY_D,
    ADSP_T_NARROW,
    ADSP_T_DIR_A,
    ADSP_T_DIR_B,
    ADSP_T_ANA_DIS,
    ADSP_T_DISP_CTRL
  } adsp_target_type;

  // plain read, whole load, and single-bit read-modify-write
  typedef enum logic [2:0] {
    ADSP_OP_NONE,
    ADSP_OP_READ,
    ADSP_OP_LOAD,
    ADSP_OP_SET,
    ADSP_OP_CLR,
    ADSP_OP_CPL
  } adsp_op_type;

  typedef struct packed {
    logic valid;
    adsp_op_type op;
    adsp_target_type target;
    logic [2:0] bit_idx;
    logic [7:0] data;
  } adsp_cmd_type;

  typedef struct packed {
    logic valid;
    logic refused;
    logic [7:0] data;
  } adsp_rsp_type;

endpackage

// ===== adsp_port_slice.sv
// Purpose: one port: output latch, optional direction register, pin sync, read mux
// Assumes: drv_en/drv_data come from the display driver on clk_sys
// Notes: without a direction register the latch itself drives (latch 1 = drive)
`timescale 1ns/10ps
`include "adsp_regs.svh"

module adsp_port_slice #(
  parameter int WIDTH = `ADSP_DATA_W,
  parameter bit HAS_DIR = 1'b1
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic wr_latch,
  input wire logic wr_dir,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] drv_en,
  input wire logic [WIDTH-1:0] drv_data,
  input wire logic [WIDTH-1:0] analog_sel,
  input wire logic conv_busy,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] read_val,
  output logic [WIDTH-1:0] latch_val
);
  logic [WIDTH-1:0] latch_q; // output latch
  logic [WIDTH-1:0] dir_q; // 1 = output
  logic [WIDTH-1:0] pin_s1_q; // first sync stage, read only by pin_s2_q
  logic [WIDTH-1:0] pin_s2_q; // pin level safe to use
  logic [WIDTH-1:0] dir_eff; // effective output mode
  logic [WIDTH-1:0] out_mode; // pins reading back the latch
  logic [WIDTH-1:0] gate_zero; // analog pins forced to zero

  // latch written whatever the direction, so data can be set up first
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      latch_q <= {WIDTH{`ADSP_RST_BIT}};
    end else if (wr_latch) begin
      latch_q <= wr_data;
    end
  end

  // direction register, write-only from outside
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dir_q <= {WIDTH{`ADSP_RST_BIT}};
    end else if (wr_dir && HAS_DIR) begin
      dir_q <= wr_data;
    end
  end

  // two-stage synchroniser on the pins
  always_ff @(posedge clk_sys) begin
    pin_s1_q <= pin_in;
    pin_s2_q <= pin_s1_q;
  end

  // 0 = input, 1 = output; display ports drive while latch is 1
  assign dir_eff = HAS_DIR ? dir_q : latch_q;
  assign out_mode = dir_eff & ~drv_en;
  assign gate_zero = analog_sel & {WIDTH{conv_busy}};

  // read: analog gate first, then latch for outputs, pin for inputs
  assign read_val = ~gate_zero & ((out_mode & latch_q) | (~out_mode & pin_s2_q));
  assign latch_val = latch_q;

  // pin drivers registered; segment driver overrides the port latch
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_out <= {WIDTH{`ADSP_RST_BIT}};
      pin_oe <= {WIDTH{`ADSP_RST_BIT}};
    end else begin
      pin_out <= (drv_en & drv_data) | (~drv_en & latch_q);
      pin_oe <= drv_en | dir_eff;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  latch_load_a: assert property (wr_latch |=> latch_q == $past(wr_data))
    else $error("latch did not take written data");
  analog_zero_a: assert property (conv_busy |-> (read_val & analog_sel) == '0)
    else $error("analog pin read nonzero while converter busy");
  pin_read_a: assert property (
      ##2 (~out_mode & ~gate_zero) == {WIDTH{1'b1}}
      |-> read_val == $past(pin_in, 2))
    else $error("input pin read does not follow synchronised pin");
  // the default disable would kill every attempt that starts in reset
  reset_clear_a: assert property (@(posedge clk_sys) disable iff (1'b0)
      srst |=> latch_q == '0 && dir_q == '0)
    else $error("reset left latch or direction set");
endmodule // adsp_port_slice

// ===== adsp_ports.sv
// Purpose: analog-shared and display-shared ports with their control registers
// Assumes: cmd from the cpu core on clk_sys; pins asynchronous
// Notes: one command per cycle, reads answer one cycle later
`timescale 1ns/10ps
`include "adsp_regs.svh"

module adsp_ports #(
  parameter int NARROW_W = `ADSP_NARROW_W
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire adsp_pkg::adsp_cmd_type cmd,
  output adsp_pkg::adsp_rsp_type rsp,
  input wire logic [`ADSP_WIDE_PORTS-1:0][7:0] wide_pin_in,
  output logic [`ADSP_WIDE_PORTS-1:0][7:0] wide_pin_out,
  output logic [`ADSP_WIDE_PORTS-1:0][7:0] wide_pin_oe,
  input wire logic [NARROW_W-1:0] display_port_narrow_in,
  output logic [NARROW_W-1:0] display_port_narrow_out,
  output logic [NARROW_W-1:0] display_port_narrow_oe,
  input wire logic conv_busy,
  input wire logic [`ADSP_ANALOG_PORTS-1:0][7:0] conv_channel_select,
  output logic analog_input_enable,
  input wire logic [3:0][7:0] disp_drv_en,
  input wire logic [3:0][7:0] disp_drv_data,
  input wire logic [NARROW_W-1:0] disp_drv_narrow_data,
  output logic [5:0] segment_select_field
);
  localparam int WP = `ADSP_WIDE_PORTS; // 8-bit ports in the array
  localparam int AP = `ADSP_ANALOG_PORTS; // the first AP of them are analog

  logic [WP-1:0][7:0] wide_read; // per-port read value
  logic [WP-1:0][7:0] wide_latch; // per-port latch contents, used only by the assertions
  logic [WP-1:0] wr_latch; // latch write strobes
  logic [WP-1:0] wr_dir; // direction write strobes
  logic [NARROW_W-1:0] narrow_read; // narrow port read value
  logic [NARROW_W-1:0] narrow_latch; // narrow port latch
  logic wr_narrow; // narrow latch write strobe
  logic analog_disable_q; // analog input disable select
  logic [5:0] seg_sel_q; // segment select field
  adsp_pkg::adsp_rsp_type rsp_q; // registered answer
  logic [7:0] cur_val; // value the addressed location reads as
  logic [7:0] bit_mask; // one-hot bit for bit operations
  logic [7:0] wr_val; // value a write stores
  logic is_bitop; // single-bit read-modify-write
  logic is_write; // any operation that stores
  logic to_dir; // addresses a direction register
  logic refuse; // bit operation on a write-only register
  logic accept_wr; // a store that goes ahead

  // command decode
  always_comb begin
    is_bitop = (cmd.op == adsp_pkg::ADSP_OP_SET) ||
               (cmd.op == adsp_pkg::ADSP_OP_CLR) ||
               (cmd.op == adsp_pkg::ADSP_OP_CPL);
    is_write = is_bitop || (cmd.op == adsp_pkg::ADSP_OP_LOAD);
    to_dir = (cmd.target == adsp_pkg::ADSP_T_DIR_A) ||
             (cmd.target == adsp_pkg::ADSP_T_DIR_B);
  end

  // a bit op cannot read back a write-only register, so it is refused
  assign refuse = cmd.valid && is_bitop && to_dir;
  assign accept_wr = cmd.valid && is_write && !refuse;
  assign bit_mask = 8'h01 << cmd.bit_idx;

  // read mux: what any read or the read half of a bit op sees
  always_comb begin
    cur_val = `ADSP_WO_READ;
    case (cmd.target)
      adsp_pkg::ADSP_T_ANALOG_A: cur_val = wide_read[0];
      adsp_pkg::ADSP_T_ANALOG_B: cur_val = wide_read[1];
      adsp_pkg::ADSP_T_DISPLAY_A: cur_val = wide_read[2];
      adsp_pkg::ADSP_T_DISPLAY_B: cur_val = wide_read[3];
      adsp_pkg::ADSP_T_DISPLAY_C: cur_val = wide_read[4];
      adsp_pkg::ADSP_T_DISPLAY_D: cur_val = wide_read[5];
      // upper bits have no pins behind them
      adsp_pkg::ADSP_T_NARROW: cur_val = {`ADSP_UNDEF_FILL, narrow_read};
      // direction registers cannot be read back
      adsp_pkg::ADSP_T_DIR_A: cur_val = `ADSP_WO_READ;
      adsp_pkg::ADSP_T_DIR_B: cur_val = `ADSP_WO_READ;
      adsp_pkg::ADSP_T_ANA_DIS: cur_val = {7'h00, analog_disable_q};
      adsp_pkg::ADSP_T_DISP_CTRL: cur_val = {`ADSP_CTRL_PAD, seg_sel_q};
      default: cur_val = `ADSP_WO_READ;
    endcase
  end

  // store value; bit ops start from the read value, so input pins
  // write their pin level back into their latch
  always_comb begin
    case (cmd.op)
      adsp_pkg::ADSP_OP_LOAD: wr_val = cmd.data;
      adsp_pkg::ADSP_OP_SET: wr_val = cur_val | bit_mask;
      adsp_pkg::ADSP_OP_CLR: wr_val = cur_val & ~bit_mask;
      adsp_pkg::ADSP_OP_CPL: wr_val = cur_val ^ bit_mask;
      default: wr_val = cmd.data;
    endcase
  end

  // write strobes per port; array index follows the target order
  always_comb begin
    for (int i = 0; i < WP; i++) begin
      wr_latch[i] = accept_wr && (cmd.target == adsp_pkg::adsp_target_type'(4'(i)));
    end
    wr_dir[0] = accept_wr && (cmd.target == adsp_pkg::ADSP_T_DIR_A);
    wr_dir[1] = accept_wr && (cmd.target == adsp_pkg::ADSP_T_DIR_B);
    for (int i = AP; i < WP; i++) begin
      wr_dir[i] = 1'b0;
    end
    wr_narrow = accept_wr && (cmd.target == adsp_pkg::ADSP_T_NARROW);
  end

  // analog input disable select; cleared means pins stay analog
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      analog_disable_q <= `ADSP_RST_ANA_DIS;
    end else if (accept_wr && cmd.target == adsp_pkg::ADSP_T_ANA_DIS) begin
      analog_disable_q <= wr_val[`ADSP_ANA_DIS_BIT];
    end
  end
  assign analog_input_enable = !analog_disable_q;

  // display control one: segment select field
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      seg_sel_q <= `ADSP_RST_SEGSEL;
    end else if (accept_wr && cmd.target == adsp_pkg::ADSP_T_DISP_CTRL) begin
      seg_sel_q <= wr_val[`ADSP_SEGSEL_MSB:`ADSP_SEGSEL_LSB];
    end
  end
  assign segment_select_field = seg_sel_q;

  // answer: reads and refusals show one cycle after the command
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rsp_q <= '0;
    end else begin
      rsp_q.valid <= cmd.valid && (cmd.op == adsp_pkg::ADSP_OP_READ);
      rsp_q.refused <= refuse;
      rsp_q.data <= cur_val;
    end
  end
  assign rsp = rsp_q;

  // the six 8-bit ports; analog ones carry a direction register
  for (genvar g = 0; g < WP; g++) begin : g_wide
    logic [7:0] drv_en_g; // segment/grid driver enables
    logic [7:0] drv_data_g; // segment/grid driver levels
    logic [7:0] analog_g; // pins taken by the converter
    if (g < AP) begin : g_analog
      // only a selected channel with analog enabled reads zero
      assign analog_g = conv_channel_select[g] & {8{!analog_disable_q}};
      assign drv_en_g = 8'h00;
      assign drv_data_g = 8'h00;
    end else begin : g_display
      assign analog_g = 8'h00;
      assign drv_en_g = disp_drv_en[g-AP];
      assign drv_data_g = disp_drv_data[g-AP];
    end
    adsp_port_slice #(
      .WIDTH(8),
      .HAS_DIR(g < AP)
    ) u_port (
      .clk_sys(clk_sys),
      .srst(srst),
      .wr_latch(wr_latch[g]),
      .wr_dir(wr_dir[g]),
      .wr_data(wr_val),
      .pin_in(wide_pin_in[g]),
      .drv_en(drv_en_g),
      .drv_data(drv_data_g),
      .analog_sel(analog_g),
      .conv_busy(conv_busy),
      .pin_out(wide_pin_out[g]),
      .pin_oe(wide_pin_oe[g]),
      .read_val(wide_read[g]),
      .latch_val(wide_latch[g])
    );
  end

  // narrow display port; field bit k hands pin k to the segment driver,
  // the top field bit has no pin here
  adsp_port_slice #(
    .WIDTH(NARROW_W),
    .HAS_DIR(1'b0)
  ) u_narrow (
    .clk_sys(clk_sys),
    .srst(srst),
    .wr_latch(wr_narrow),
    .wr_dir(1'b0),
    .wr_data(wr_val[NARROW_W-1:0]),
    .pin_in(display_port_narrow_in),
    .drv_en(seg_sel_q[NARROW_W-1:0]),
    .drv_data(disp_drv_narrow_data),
    .analog_sel({NARROW_W{1'b0}}),
    .conv_busy(conv_busy),
    .pin_out(display_port_narrow_out),
    .pin_oe(display_port_narrow_oe),
    .read_val(narrow_read),
    .latch_val(narrow_latch)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  read_answer_a: assert property (
      cmd.valid && cmd.op == adsp_pkg::ADSP_OP_READ
      |=> rsp.valid && rsp.data == $past(cur_val))
    else $error("read answer missing or wrong one cycle later");
  dir_refuse_a: assert property (
      cmd.valid && is_bitop && to_dir
      |=> rsp.refused && !rsp.valid)
    else $error("bit operation on direction register not refused");
  dir_noread_a: assert property (
      cmd.valid && cmd.op == adsp_pkg::ADSP_OP_READ && to_dir
      |=> rsp.data == 8'h00)
    else $error("direction register read back nonzero");
  narrow_fill_a: assert property (
      cmd.valid && cmd.op == adsp_pkg::ADSP_OP_READ &&
      cmd.target == adsp_pkg::ADSP_T_NARROW |=> rsp.data[7:5] == `ADSP_UNDEF_FILL)
    else $error("narrow port upper bits not the fill value");
  // reset checks must not be switched off by the reset they watch
  reset_state_a: assert property (@(posedge clk_sys) disable iff (1'b0)
      srst |=> analog_input_enable && segment_select_field == 6'h00)
    else $error("reset did not select analog input and port function");
  seg_write_a: assert property (
      accept_wr && cmd.target == adsp_pkg::ADSP_T_DISP_CTRL
      |=> segment_select_field == $past(wr_val[5:0]) ##1
      (display_port_narrow_oe & segment_select_field[NARROW_W-1:0]) ==
      segment_select_field[NARROW_W-1:0])
    else $error("segment field write did not hand pins to the driver");
  bitop_rmw_a: assert property (
      accept_wr && is_bitop &&
      cmd.target == adsp_pkg::ADSP_T_ANALOG_A |=> wide_latch[0] == $past(wr_val))
    else $error("bit operation did not write back read value");
  display_reset_a: assert property (@(posedge clk_sys) disable iff (1'b0)
      srst |=> wide_latch[5:2] == '0 && narrow_latch == '0)
    else $error("display latches not cleared by reset");

  bitop_cover_c: cover property (accept_wr && is_bitop);
  analog_read_c: cover property (conv_busy && cmd.valid &&
      cmd.op == adsp_pkg::ADSP_OP_READ && cmd.target == adsp_pkg::ADSP_T_ANALOG_B);
  refuse_cover_c: cover property (refuse);
  seg_use_c: cover property (segment_select_field != 6'h00);
endmodule // adsp_ports

// ===== adsp_pin_model.sv
// Purpose: pin-level model of the board around the shared ports
// Assumes: outside levels come from the testbench; an enabled design driver wins
// Notes: these pins have no pulls, so an undriven pin shows the outside level
`timescale 1ns/10ps
module adsp_pin_model #(
  parameter int NARROW_W = 5
) (
  input wire logic [5:0][7:0] ext_wide,
  input wire logic [NARROW_W-1:0] ext_narrow,
  input wire logic [5:0][7:0] pin_out,
  input wire logic [5:0][7:0] pin_oe,
  input wire logic [NARROW_W-1:0] nar_out,
  input wire logic [NARROW_W-1:0] nar_oe,
  output logic [5:0][7:0] wide_lvl,
  output logic [NARROW_W-1:0] nar_lvl
);
  // wire level per pin: driven bits follow the design, the rest the outside world
  always_comb begin
    for (int p = 0; p < 6; p++) begin
      wide_lvl[p] = (pin_oe[p] & pin_out[p]) | (~pin_oe[p] & ext_wide[p]);
    end
    nar_lvl = (nar_oe & nar_out) | (~nar_oe & ext_narrow);
  end
endmodule // adsp_pin_model

// ===== tb.sv
// Purpose: self-checking bench for the analog and display shared ports
// Assumes: commands answered one cycle after they are taken
// Notes: pin waits cover the registered drive plus two-flop sync
`timescale 1ns/10ps
module tb;
  logic clk_sys;
  logic srst;
  adsp_pkg::adsp_cmd_type cmd;
  adsp_pkg::adsp_rsp_type rsp;
  logic [5:0][7:0] pin_in, pin_out, pin_oe, ext_wide;
  logic [4:0] nar_in, nar_out, nar_oe, ext_nar, drv_nar;
  logic conv_busy;
  logic [1:0][7:0] conv_sel;
  logic ain_en;
  logic [3:0][7:0] drv_en, drv_data;
  logic [5:0] seg;
  int n_mismatch;
  int n_tests;
  adsp_ports i_adsp_ports (.clk_sys(clk_sys), .srst(srst), .cmd(cmd), .rsp(rsp),
    .wide_pin_in(pin_in), .wide_pin_out(pin_out), .wide_pin_oe(pin_oe),
    .display_port_narrow_in(nar_in), .display_port_narrow_out(nar_out),
    .display_port_narrow_oe(nar_oe), .conv_busy(conv_busy), .conv_channel_select(conv_sel),
    .analog_input_enable(ain_en), .disp_drv_en(drv_en), .disp_drv_data(drv_data),
    .disp_drv_narrow_data(drv_nar), .segment_select_field(seg));
  adsp_pin_model i_adsp_pin_model (.ext_wide(ext_wide), .ext_narrow(ext_nar),
    .pin_out(pin_out), .pin_oe(pin_oe), .nar_out(nar_out), .nar_oe(nar_oe),
    .wide_lvl(pin_in), .nar_lvl(nar_in));
  // free-running system clock, 100 ns period
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // single compare point, four-state so unknowns never match
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one command, held for one edge; answer sampled just after the taking edge
  task automatic xfer(input adsp_pkg::adsp_op_type op, input adsp_pkg::adsp_target_type tg,
      input logic [2:0] bi, input logic [7:0] d, output adsp_pkg::adsp_rsp_type r);
    @(posedge clk_sys);
    cmd <= '{valid: 1'b1, op: op, target: tg, bit_idx: bi, data: d};
    @(posedge clk_sys);
    cmd <= '0;
    #1;
    r = rsp;
  endtask
  task automatic ld(input adsp_pkg::adsp_target_type tg, input logic [7:0] d);
    adsp_pkg::adsp_rsp_type r;
    xfer(adsp_pkg::ADSP_OP_LOAD, tg, 3'h0, d, r);
  endtask
  task automatic rd_chk(input adsp_pkg::adsp_target_type tg, input logic [7:0] exp,
      input string msg);
    adsp_pkg::adsp_rsp_type r;
    xfer(adsp_pkg::ADSP_OP_READ, tg, 3'h0, 8'h00, r);
    check({7'h00, r.valid}, 8'h01, msg);
    check(r.data, exp, msg);
  endtask
  // registered drive plus two sync flops, with a cycle of margin
  task automatic settle;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  adsp_pkg::adsp_rsp_type r_tmp; // answer of commands whose reply is looked at by hand
  // pin outputs and control state right after a reset
  task automatic t_reset_state;
    for (int p = 0; p < 6; p++) begin
      check(pin_oe[p], 8'h00, "oe after reset");
      check(pin_out[p], 8'h00, "out after reset");
    end
    check({3'h0, nar_oe | nar_out}, 8'h00, "narrow after reset");
    check({7'h00, ain_en}, 8'h01, "analog mode after reset");
    check({2'h0, seg}, 8'h00, "segment field after reset");
    rd_chk(adsp_pkg::ADSP_T_DIR_A, 8'h00, "direction reads zero");
    $display("test reset_state done");
  endtask
  // per-bit direction, mixed read and the bit-op write-back hazard
  task automatic t_direction;
    ld(adsp_pkg::ADSP_T_ANALOG_A, 8'h0A);
    ld(adsp_pkg::ADSP_T_DIR_A, 8'h0F);
    settle();
    check(pin_oe[0], 8'h0F, "dir sets enables");
    check(pin_out[0], 8'h0A, "latch drives");
    rd_chk(adsp_pkg::ADSP_T_ANALOG_A, 8'h5A, "mixed read");
    xfer(adsp_pkg::ADSP_OP_SET, adsp_pkg::ADSP_T_ANALOG_A, 3'h2, 8'h00, r_tmp);
    ld(adsp_pkg::ADSP_T_DIR_A, 8'hFF);
    settle();
    check(pin_out[0], 8'h5E, "bit op wrote pin levels");
    // all outputs now: clear and complement start from the latch
    xfer(adsp_pkg::ADSP_OP_CLR, adsp_pkg::ADSP_T_ANALOG_A, 3'h3, 8'h00, r_tmp);
    check({7'h00, r_tmp.refused}, 8'h00, "port clr accepted");
    xfer(adsp_pkg::ADSP_OP_CPL, adsp_pkg::ADSP_T_ANALOG_A, 3'h0, 8'h00, r_tmp);
    rd_chk(adsp_pkg::ADSP_T_ANALOG_A, 8'h57, "clr and cpl on outputs");
    $display("test direction done");
  endtask
  // read-modify-write on a direction register is turned away
  task automatic t_refuse;
    xfer(adsp_pkg::ADSP_OP_CLR, adsp_pkg::ADSP_T_DIR_A, 3'h0, 8'h00, r_tmp);
    check({7'h00, r_tmp.refused}, 8'h01, "clr refused");
    xfer(adsp_pkg::ADSP_OP_CPL, adsp_pkg::ADSP_T_DIR_B, 3'h7, 8'h00, r_tmp);
    check({7'h00, r_tmp.refused}, 8'h01, "cpl refused");
    settle();
    check(pin_oe[0], 8'hFF, "direction kept");
    check(pin_oe[1], 8'h00, "direction b kept");
    $display("test refuse done");
  endtask
  // converter busy masks analog pins only while analog select is on
  task automatic t_analog;
    @(posedge clk_sys);
    conv_sel[1] <= 8'h33;
    conv_busy <= 1'b1;
    settle();
    rd_chk(adsp_pkg::ADSP_T_ANALOG_B, 8'hCC, "busy masks analog");
    @(posedge clk_sys);
    conv_busy <= 1'b0;
    settle();
    rd_chk(adsp_pkg::ADSP_T_ANALOG_B, 8'hFF, "idle reads pins");
    @(posedge clk_sys);
    conv_busy <= 1'b1;
    ld(adsp_pkg::ADSP_T_ANA_DIS, 8'h01);
    settle();
    check({7'h00, ain_en}, 8'h00, "analog disabled");
    rd_chk(adsp_pkg::ADSP_T_ANALOG_B, 8'hFF, "digital while busy");
    rd_chk(adsp_pkg::ADSP_T_ANA_DIS, 8'h01, "select readback");
    ld(adsp_pkg::ADSP_T_ANA_DIS, 8'h00);
    $display("test analog done");
  endtask
  // display ports: latch drives as port, driver takes claimed pins
  task automatic t_display;
    ld(adsp_pkg::ADSP_T_DISPLAY_A, 8'h81);
    @(posedge clk_sys);
    drv_en[1] <= 8'h0F;
    drv_data[1] <= 8'h05;
    settle();
    check(pin_oe[2], 8'h81, "port a enables");
    check(pin_out[2], 8'h81, "port a level");
    rd_chk(adsp_pkg::ADSP_T_DISPLAY_A, 8'hBD, "port a read");
    check(pin_oe[3], 8'h0F, "driver enables");
    check(pin_out[3], 8'h05, "driver level");
    check(pin_oe[4], 8'h00, "unclaimed port idle");
    $display("test display done");
  endtask
  // narrow port: segment field hands pins over, upper read bits fixed
  task automatic t_narrow;
    @(posedge clk_sys);
    drv_nar <= 5'h02;
    rd_chk(adsp_pkg::ADSP_T_NARROW, 8'h15, "narrow as port");
    ld(adsp_pkg::ADSP_T_DISP_CTRL, 8'h03);
    settle();
    check({2'h0, seg}, 8'h03, "segment field");
    check({3'h0, nar_oe}, 8'h03, "segment enables");
    check({3'h0, nar_out}, 8'h02, "segment level");
    rd_chk(adsp_pkg::ADSP_T_NARROW, 8'h16, "narrow mixed read");
    rd_chk(adsp_pkg::ADSP_T_DISP_CTRL, 8'h03, "control readback");
    $display("test narrow done");
  endtask
  // second reset with everything dirtied clears latches and directions
  task automatic t_mid_reset;
    @(posedge clk_sys);
    drv_en <= '0;
    drv_nar <= 5'h00;
    conv_busy <= 1'b0;
    srst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    #1;
    t_reset_state();
    rd_chk(adsp_pkg::ADSP_T_ANALOG_A, 8'h5C, "direction cleared");
    rd_chk(adsp_pkg::ADSP_T_DISPLAY_A, 8'h3C, "display latch cleared");
    $display("test mid_reset done");
  endtask
  initial begin
    n_mismatch = 0;
    n_tests = 0;
    srst = 1'b1;
    cmd = '0;
    conv_busy = 1'b0;
    conv_sel = {8'h00, 8'hFF};
    drv_en = '0;
    drv_data = '0;
    drv_nar = 5'h00;
    ext_wide = {8'h00, 8'h00, 8'h00, 8'h3C, 8'hFF, 8'h5C};
    ext_nar = 5'h15;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    #1;
    t_reset_state();
    t_direction();
    t_refuse();
    t_analog();
    t_display();
    t_narrow();
    t_mid_reset();
    finish_test();
  end
  // guard against a hung run
  initial begin
    #3000000;
    n_mismatch++;
    $display("CHECK FAILED t=%0t run limit reached", $time);
    finish_test();
  end
endmodule // tb
